/* rtl/ase_defs.svh */
// Register offsets, field positions and timing counts for the serial element.
`ifndef ASE_DEFS_SVH
`define ASE_DEFS_SVH
`define ASE_OFS_DATA 3'h0
`define ASE_OFS_IEN 3'h1
`define ASE_OFS_ISRC 3'h2
`define ASE_OFS_FMT 3'h3
`define ASE_OFS_HOUT 3'h4
`define ASE_OFS_LINK 3'h5
`define ASE_OFS_HIN 3'h6
`define ASE_OFS_SCR 3'h7
`define ASE_FMT_DIVACC 7
`define ASE_FMT_BREAK 6
`define ASE_FMT_STICK 5
`define ASE_FMT_EVEN 4
`define ASE_FMT_PARON 3
`define ASE_FMT_STOP 2
`define ASE_HOUT_LOOP 4
`define ASE_DIV_RESET 16'h000C
`define ASE_OVERSAMPLE 4'hF
`define ASE_MID_SAMPLE 4'h7
`define ASE_ID_MODEM 2'h0
`define ASE_ID_TXE 2'h1
`define ASE_ID_RXA 2'h2
`define ASE_ID_LINE 2'h3
`define ASE_FIFO_DEPTH 8
`endif

/* rtl/ase_pkg.sv */
// Types shared by the serial element design.
package ase_pkg;
    typedef enum logic [1:0] {
        ASE_TX_IDLE = 2'b00,
        ASE_TX_START = 2'b01,
        ASE_TX_BITS = 2'b10,
        ASE_TX_STOP = 2'b11
    } ase_tx_e;
    typedef enum logic [1:0] {
        ASE_RX_IDLE = 2'b00,
        ASE_RX_START = 2'b01,
        ASE_RX_BITS = 2'b10,
        ASE_RX_STOP = 2'b11
    } ase_rx_e;
endpackage

/* rtl/ase_serial_element.sv */
// Serial element: host registers, baud generator, transmitter, receiver.
// Functional notes
// - Frame is start, 5-8 data, optional parity, 1, 1.5 or 2 stops.
// - Baud divisor 1..65535 divides core clock to 16x bit rate tick.
// - Receiver runs from the same 16x tick as the transmitter.
// - With divisor access set, offsets 0/1 reach divisor low/high byte.
// - Divisor access clear, offset 0 read returns received byte.
// - Divisor access clear, offset 0 write loads transmit holding byte.
// - Irq enable bits 0-3: rx data, tx empty, line, modem; rest zero.
// - Irq source: bit0 low when pending, bits 2:1 code, rest zero.
// - Format bits 1:0 select five to eight data bits.
// - Format bits 2-6: stops, parity on, even, stick, break.
// - Format bit 7 is divisor access, redirecting offsets 0 and 1.
// - Handshake outputs: DTR, RTS, out1, out2, loopback; rest zero.
// - Link bits 0-4: ready, overrun, parity, framing, break seen.
// - Link bit 5 holding empty, bit 6 shifter empty, bit 7 zero.
// - Handshake input bits 0, 1, 3 latch changes since last read; bit 2 latches only a fall of RI.
// - Handshake input bits 4-7 show CTS, DSR, RI, carrier now.
`timescale 1ns/10ps
`include "ase_defs.svh"

module ase_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic srst,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } ase_fifo_s;
    ase_fifo_s st_reg, st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // Handshakes reflect honest full and empty.
    assign in_ready = st_reg.cnt != (AW+1)'(DEPTH);
    assign out_valid = st_reg.cnt != '0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[st_reg.rp];

    // Pointer and count update.
    always_comb
    begin
        st_next = st_reg;
        if (push)
            st_next.wp = st_reg.wp + 1'b1;
        if (pop)
            st_next.rp = st_reg.rp + 1'b1;
        st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Storage is written without reset since contents are qualified.
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[st_reg.wp] <= in_data;
        if (srst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
endmodule

module ase_serial_element
    import ase_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic srst,
    // Host register port.
    input wire logic [2:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic irq,
    // Serial line.
    output logic ser_out,
    input wire logic ser_in,
    // Modem control outputs and status inputs.
    output logic dtr,
    output logic rts,
    output logic out1,
    output logic out2,
    input wire logic cts,
    input wire logic dsr,
    input wire logic ri,
    input wire logic carrier
);
    typedef struct packed {
        logic [7:0] fmt;
        logic [3:0] ien;
        logic [4:0] hout;
        logic [7:0] scr;
        logic [15:0] div;
        logic [15:0] bcnt;
        logic tick;
        logic [4:0] sin1, sin2, sin3;
        logic [4:0] sin_f;
        logic [3:0] hin_prev;
        logic [3:0] hin_delta;
        ase_tx_e tx_st;
        logic [3:0] tx_sub;
        logic [3:0] tx_bit;
        logic [8:0] tx_sh;
        logic txd;
        logic [4:0] tx_stop_len;
        ase_rx_e rx_st;
        logic [3:0] rx_sub;
        logic [3:0] rx_bit;
        logic [8:0] rx_sh;
        logic [7:0] rbuf;
        logic rdy, ovr, perr, ferr, brk;
        logic txe_irq;
        logic [7:0] rdata;
    } ase_s;
    ase_s s_reg, s_next;

    logic hold_valid, hold_ready, fifo_in_ready, fifo_pop;
    logic [7:0] hold_data;
    logic wr_hold, rx_line;
    logic [3:0] hin_now, len;
    logic [1:0] id_code;
    logic pend, rx_done, tx_take;
    logic [3:0] hin_evt;

    // Number of data bits from the two select bits.
    function automatic logic [3:0] word_len(input logic [1:0] sel);
        word_len = 4'h5 + {2'b00, sel};
    endfunction

    // Parity of the data bits actually sent, with even/stick options.
    function automatic logic par_bit(input logic [7:0] d,
        input logic [1:0] sel, input logic [7:0] f);
        logic [7:0] m;
        logic p;
        m = 8'hFF >> (3'h3 - 3'(sel));
        p = ^(d & m);
        if (f[`ASE_FMT_STICK])
            par_bit = ~f[`ASE_FMT_EVEN];
        else
            par_bit = f[`ASE_FMT_EVEN] ? p : ~p;
    endfunction

    // Writes to offset 0 with divisor access clear fill the holding FIFO; the FIFO's ready drops
    // when full, so a write that finds it full is discarded.
    assign wr_hold = reg_wr && reg_addr == `ASE_OFS_DATA
        && !s_reg.fmt[`ASE_FMT_DIVACC];
    assign fifo_in_ready = hold_ready;

    ase_fifo #(.WIDTH(8), .DEPTH(`ASE_FIFO_DEPTH)) u_hold (
        .core_clk(core_clk),
        .srst(srst),
        .in_valid(wr_hold),
        .in_ready(hold_ready),
        .in_data(reg_wdata),
        .out_valid(hold_valid),
        .out_ready(fifo_pop),
        .out_data(hold_data)
    );

    // Loopback swaps line and modem sources.
    assign len = word_len(s_reg.fmt[1:0]);
    assign rx_line = s_reg.hout[`ASE_HOUT_LOOP] ? s_reg.txd
        : s_reg.sin_f[0];
    assign hin_now = s_reg.hout[`ASE_HOUT_LOOP]
        ? {s_reg.hout[2], s_reg.hout[3], s_reg.hout[0], s_reg.hout[1]}
        : s_reg.sin_f[4:1];
    assign fifo_pop = s_reg.tx_st == ASE_TX_IDLE && s_reg.tick;

    // Event strobes let a same-cycle set win over a clearing access.
    assign tx_take = fifo_pop && hold_valid;
    assign rx_done = s_reg.tick && s_reg.rx_st == ASE_RX_STOP
        && s_reg.rx_sub == `ASE_OVERSAMPLE;
    assign hin_evt = {hin_now[3] ^ s_reg.hin_prev[3],
        s_reg.hin_prev[2] & ~hin_now[2], hin_now[1] ^ s_reg.hin_prev[1],
        hin_now[0] ^ s_reg.hin_prev[0]};

    // Interrupt priority: line, rx data, tx empty, modem.
    always_comb
    begin
        pend = 1'b1;
        id_code = `ASE_ID_MODEM;
        if (s_reg.ien[2] && (s_reg.ovr || s_reg.perr || s_reg.ferr
            || s_reg.brk))
            id_code = `ASE_ID_LINE;
        else if (s_reg.ien[0] && s_reg.rdy)
            id_code = `ASE_ID_RXA;
        else if (s_reg.ien[1] && s_reg.txe_irq)
            id_code = `ASE_ID_TXE;
        else if (s_reg.ien[3] && s_reg.hin_delta != 4'h0)
            id_code = `ASE_ID_MODEM;
        else
            pend = 1'b0;
    end

    always_comb
    begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        // Three-stage pin capture; a bit is taken once stages two and three
        // agree, so a pin caught mid-change never reaches the logic.
        s_next.sin1 = {carrier, ri, dsr, cts, ser_in};
        s_next.sin2 = s_reg.sin1;
        s_next.sin3 = s_reg.sin2;
        s_next.sin_f = (s_reg.sin3 & ~(s_reg.sin2 ^ s_reg.sin3))
            | (s_reg.sin_f & (s_reg.sin2 ^ s_reg.sin3));
        // Baud counter: reload at divisor-1, pulse tick at zero.
        if (s_reg.bcnt == 16'h0000)
        begin
            s_next.bcnt = s_reg.div - 16'h0001;
            s_next.tick = 1'b1;
        end
        else
            s_next.bcnt = s_reg.bcnt - 16'h0001;
        // Modem change detection.
        s_next.hin_prev = hin_now;
        s_next.hin_delta = s_reg.hin_delta | hin_evt;

        // Transmitter on the 16x tick.
        if (s_reg.tick)
        begin
            s_next.tx_sub = s_reg.tx_sub + 4'h1;
            case (s_reg.tx_st)
                ASE_TX_IDLE:
                begin
                    s_next.txd = 1'b1;
                    s_next.tx_sub = 4'h0;
                    if (hold_valid)
                    begin
                        s_next.tx_sh = {par_bit(hold_data, s_reg.fmt[1:0],
                            s_reg.fmt), hold_data};
                        s_next.tx_st = ASE_TX_START;
                        s_next.txd = 1'b0;
                        s_next.txe_irq = 1'b1;
                    end
                end
                ASE_TX_START:
                    if (s_reg.tx_sub == `ASE_OVERSAMPLE)
                    begin
                        s_next.tx_st = ASE_TX_BITS;
                        s_next.tx_bit = 4'h0;
                        s_next.txd = s_reg.tx_sh[0];
                    end
                ASE_TX_BITS:
                    if (s_reg.tx_sub == `ASE_OVERSAMPLE)
                    begin
                        s_next.tx_bit = s_reg.tx_bit + 4'h1;
                        if (s_reg.tx_bit + 4'h1 == len)
                        begin
                            if (s_reg.fmt[`ASE_FMT_PARON])
                                s_next.txd = s_reg.tx_sh[8];
                            else
                            begin
                                s_next.tx_st = ASE_TX_STOP;
                                s_next.txd = 1'b1;
                            end
                        end
                        else if (s_reg.tx_bit == len)
                        begin
                            s_next.tx_st = ASE_TX_STOP;
                            s_next.txd = 1'b1;
                        end
                        else
                            s_next.txd = s_reg.tx_sh[s_reg.tx_bit[2:0] + 3'h1];
                        // Stop length in ticks: 16, 24 or 32.
                        s_next.tx_stop_len = !s_reg.fmt[`ASE_FMT_STOP]
                            ? 5'h0F : (len == 4'h5 ? 5'h17 : 5'h1F);
                    end
                ASE_TX_STOP:
                begin
                    s_next.tx_stop_len = s_reg.tx_stop_len - 5'h01;
                    if (s_reg.tx_stop_len == 5'h00)
                        s_next.tx_st = ASE_TX_IDLE;
                end
                default:
                    s_next.tx_st = ASE_TX_IDLE;
            endcase
        end

        // Receiver on the same tick, sampled mid-bit.
        if (s_reg.tick)
        begin
            s_next.rx_sub = s_reg.rx_sub + 4'h1;
            case (s_reg.rx_st)
                ASE_RX_IDLE:
                begin
                    s_next.rx_sub = 4'h0;
                    if (!rx_line)
                        s_next.rx_st = ASE_RX_START;
                end
                ASE_RX_START:
                    if (s_reg.rx_sub == `ASE_MID_SAMPLE)
                    begin
                        s_next.rx_sub = 4'h0;
                        s_next.rx_bit = 4'h0;
                        s_next.rx_sh = 9'h000;
                        s_next.rx_st = rx_line ? ASE_RX_IDLE : ASE_RX_BITS;
                    end
                ASE_RX_BITS:
                    if (s_reg.rx_sub == `ASE_OVERSAMPLE)
                    begin
                        s_next.rx_sh[s_reg.rx_bit] = rx_line;
                        s_next.rx_bit = s_reg.rx_bit + 4'h1;
                        if (s_reg.rx_bit + 4'h1 ==
                            len + 4'(s_reg.fmt[`ASE_FMT_PARON]))
                            s_next.rx_st = ASE_RX_STOP;
                    end
                ASE_RX_STOP:
                    if (s_reg.rx_sub == `ASE_OVERSAMPLE)
                    begin
                        s_next.rx_st = ASE_RX_IDLE;
                        s_next.rbuf = s_reg.rx_sh[7:0]
                            & (8'hFF >> (3'h3 - 3'(s_reg.fmt[1:0])));
                        s_next.ovr = s_reg.ovr | s_reg.rdy;
                        s_next.rdy = 1'b1;
                        s_next.ferr = s_reg.ferr | ~rx_line;
                        s_next.brk = s_reg.brk | (~rx_line
                            & s_reg.rx_sh == 9'h000);
                        if (s_reg.fmt[`ASE_FMT_PARON])
                            s_next.perr = s_reg.perr | (s_reg.rx_sh[len]
                                != par_bit(s_reg.rx_sh[7:0],
                                s_reg.fmt[1:0], s_reg.fmt));
                    end
                default:
                    s_next.rx_st = ASE_RX_IDLE;
            endcase
        end

        // Register read data; reads clear their flags unless set same cycle.
        s_next.rdata = 8'h00;
        if (reg_rd)
        begin
            if (reg_addr == `ASE_OFS_DATA)
            begin
                if (s_reg.fmt[`ASE_FMT_DIVACC])
                    s_next.rdata = s_reg.div[7:0];
                else
                begin
                    s_next.rdata = s_reg.rbuf;
                    if (!rx_done)
                        s_next.rdy = 1'b0;
                end
            end
            else if (reg_addr == `ASE_OFS_IEN)
                s_next.rdata = s_reg.fmt[`ASE_FMT_DIVACC]
                    ? s_reg.div[15:8] : {4'h0, s_reg.ien};
            else if (reg_addr == `ASE_OFS_ISRC)
            begin
                s_next.rdata = {5'h00, id_code, ~pend};
                if (pend && id_code == `ASE_ID_TXE && !tx_take)
                    s_next.txe_irq = 1'b0;
            end
            else if (reg_addr == `ASE_OFS_FMT)
                s_next.rdata = s_reg.fmt;
            else if (reg_addr == `ASE_OFS_HOUT)
                s_next.rdata = {3'h0, s_reg.hout};
            else if (reg_addr == `ASE_OFS_LINK)
            begin
                s_next.rdata = {1'b0, s_reg.tx_st == ASE_TX_IDLE
                    && !hold_valid, !hold_valid, s_reg.brk, s_reg.ferr,
                    s_reg.perr, s_reg.ovr, s_reg.rdy};
                // A frame ending in the same cycle keeps its fresh flags.
                if (!rx_done)
                    {s_next.ovr, s_next.perr, s_next.ferr,
                        s_next.brk} = 4'h0;
            end
            else if (reg_addr == `ASE_OFS_HIN)
            begin
                s_next.rdata = {hin_now[3], hin_now[2], hin_now[1],
                    hin_now[0], s_reg.hin_delta};
                s_next.hin_delta = hin_evt;
            end
            else
                s_next.rdata = s_reg.scr;
        end

        // Register writes.
        if (reg_wr)
        begin
            if (reg_addr == `ASE_OFS_DATA)
            begin
                if (s_reg.fmt[`ASE_FMT_DIVACC])
                    s_next.div[7:0] = reg_wdata;
                else if (fifo_in_ready && !tx_take)
                    s_next.txe_irq = 1'b0;
            end
            else if (reg_addr == `ASE_OFS_IEN)
            begin
                if (s_reg.fmt[`ASE_FMT_DIVACC])
                    s_next.div[15:8] = reg_wdata;
                else
                    s_next.ien = reg_wdata[3:0];
            end
            else if (reg_addr == `ASE_OFS_FMT)
                s_next.fmt = reg_wdata;
            else if (reg_addr == `ASE_OFS_HOUT)
                s_next.hout = reg_wdata[4:0];
            else if (reg_addr == `ASE_OFS_SCR)
                s_next.scr = reg_wdata;
        end
        // A zero divisor would wrap its reload to 65535, so it counts as one.
        if (s_next.div == 16'h0000)
            s_next.div = 16'h0001;
        // A new divisor restarts the count, or an old long one would linger.
        if (s_next.div != s_reg.div)
            s_next.bcnt = 16'h0000;
    end

    // Reset parks the line high and the pin capture at an idle line.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            s_reg <= '0;
            s_reg.div <= `ASE_DIV_RESET;
            s_reg.txd <= 1'b1;
            s_reg.sin1 <= 5'h01;
            s_reg.sin2 <= 5'h01;
            s_reg.sin3 <= 5'h01;
            s_reg.sin_f <= 5'h01;
        end
        else
            s_reg <= s_next;
    end

    // Outputs; loopback parks the line idle and the modem pins inactive.
    assign reg_rdata = s_reg.rdata;
    assign irq = pend;
    assign ser_out = s_reg.hout[`ASE_HOUT_LOOP] ? 1'b1
        : (s_reg.txd & ~s_reg.fmt[`ASE_FMT_BREAK]);
    assign dtr = s_reg.hout[0] & ~s_reg.hout[`ASE_HOUT_LOOP];
    assign rts = s_reg.hout[1] & ~s_reg.hout[`ASE_HOUT_LOOP];
    assign out1 = s_reg.hout[2] & ~s_reg.hout[`ASE_HOUT_LOOP];
    assign out2 = s_reg.hout[3] & ~s_reg.hout[`ASE_HOUT_LOOP];

    // Bytes written arrive in the holding FIFO in one cycle.
    chk_write_fills: assert property (@(posedge core_clk) disable iff (srst)
        wr_hold && hold_ready |=> hold_valid)
        else $error("holding write not stored");
    chk_idle_line: assert property (@(posedge core_clk) disable iff (srst)
        s_reg.hout[`ASE_HOUT_LOOP] |-> ser_out)
        else $error("line not idle in loopback");
    chk_irq_bit: assert property (@(posedge core_clk) disable iff (srst)
        reg_rd && reg_addr == `ASE_OFS_ISRC |=> reg_rdata[0] == !$past(irq))
        else $error("pending bit wrong");
    chk_tick_div: assert property (@(posedge core_clk) disable iff (srst)
        s_reg.tick && s_reg.div == 16'h0001 |=> s_reg.tick)
        else $error("divide by one missed tick");
    // Scratch round trip: a write, one quiet cycle, then a read back.
    sequence scr_write;
        reg_wr && reg_addr == `ASE_OFS_SCR;
    endsequence
    sequence scr_readback;
        !reg_wr ##1 reg_rd && reg_addr == `ASE_OFS_SCR;
    endsequence
    chk_scratch_rt: assert property (@(posedge core_clk) disable iff (srst)
        scr_write ##1 scr_readback |=> reg_rdata == $past(reg_wdata, 3))
        else $error("scratch byte lost");
    chk_ien_zero: assert property (@(posedge core_clk) disable iff (srst)
        reg_rd && reg_addr == `ASE_OFS_IEN && !s_reg.fmt[7]
        |=> reg_rdata[7:4] == 4'h0)
        else $error("irq enable upper bits set");
    chk_break_out: assert property (@(posedge core_clk) disable iff (srst)
        s_reg.fmt[`ASE_FMT_BREAK] && !s_reg.hout[`ASE_HOUT_LOOP]
        |-> !ser_out)
        else $error("break not driven");
    chk_rx_ready: assert property (@(posedge core_clk) disable iff (srst)
        s_reg.tick && s_reg.rx_st == ASE_RX_STOP
        && s_reg.rx_sub == `ASE_OVERSAMPLE |=> s_reg.rdy)
        else $error("ready not set after stop");
endmodule

/* dv/ase_term_model.sv */
// Terminal model on the far side of the serial line.
`timescale 1ns/10ps
module ase_term_model #(
    parameter int BIT = 16
) (
    // Clock.
    input wire logic core_clk,
    // Serial lines seen from the terminal.
    input wire logic line_in,
    output logic line_out
);
    logic [7:0] last_rx = 8'h00;
    logic [7:0] shift = 8'h00;
    int rx_cnt = 0;
    int bad_stop = 0;

    // The line rests high between frames, as a pulled-up idle line does.
    initial line_out = 1'b1;

    // Samples each frame in mid-bit, LSB first, eight bits, one stop.
    initial
    begin
        forever
        begin
            @(negedge line_in);
            repeat (BIT / 2) @(posedge core_clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT) @(posedge core_clk);
                shift = {line_in, shift[7:1]};
            end
            repeat (BIT) @(posedge core_clk);
            if (line_in !== 1'b1) bad_stop++;
            last_rx = shift;
            rx_cnt++;
        end
    end

    // Sends one frame: start low, data LSB first, stop high.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge core_clk);
            line_out <= f[i];
            repeat (BIT - 1) @(posedge core_clk);
        end
    endtask
endmodule

/* dv/tb_ase_serial_element.sv */
// Self-checking bench for the serial element.
`timescale 1ns/10ps
module tb_ase_serial_element;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic irq, ser_out, ser_in, dtr, rts, out1, out2;
    logic cts = 1'b0;
    logic dsr = 1'b0;
    logic ri = 1'b0;
    logic carrier = 1'b0;
    logic [7:0] hi_cnt;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;

    ase_serial_element dut (.core_clk(core_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq(irq),
        .ser_out(ser_out), .ser_in(ser_in), .dtr(dtr), .rts(rts),
        .out1(out1), .out2(out2), .cts(cts), .dsr(dsr), .ri(ri),
        .carrier(carrier));

    // Divisor 1 gives sixteen core clocks per bit.
    ase_term_model #(.BIT(16)) term (.core_clk(core_clk),
        .line_in(ser_out), .line_out(ser_in));

    // Free-running 20 MHz clock.
    initial forever #25 core_clk = ~core_clk;

    // A hang is cut short well after the tests should have ended.
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic ck(input string what, input logic [7:0] exp,
        input logic [7:0] seen);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One write strobe, held for exactly one sampling edge.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands for the cycle after the read edge only.
    task automatic rck(input logic [2:0] a, input logic [7:0] exp,
        input string what);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        ck(what, exp, reg_rdata);
    endtask

    // Main sequence.
    initial
    begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        rck(3'h2, 8'h01, "irq source idle");
        rck(3'h5, 8'h60, "link idle");
        rck(3'h4, 8'h00, "hout reset");
        wr(3'h3, 8'h83);
        rck(3'h0, 8'h0C, "div low reset");
        rck(3'h1, 8'h00, "div high reset");
        wr(3'h1, 8'h12);
        rck(3'h1, 8'h12, "div high");
        wr(3'h0, 8'h01);
        wr(3'h1, 8'h00);
        rck(3'h0, 8'h01, "div low");
        wr(3'h3, 8'h03);
        rck(3'h3, 8'h03, "format");
        wr(3'h7, 8'hA5);
        rck(3'h7, 8'hA5, "scratch");
        wr(3'h0, 8'h5A);
        for (int i = 0; i < 400 && term.rx_cnt < 1; i++)
            @(posedge core_clk);
        ck("tx byte", 8'h5A, term.last_rx);
        // The stop bit is still leaving the shifter when the terminal is done.
        repeat (20) @(posedge core_clk);
        rck(3'h5, 8'h60, "link after tx");
        term.send(8'hC3);
        repeat (20) @(posedge core_clk);
        rck(3'h5, 8'h61, "link rx ready");
        rck(3'h0, 8'hC3, "rx byte");
        rck(3'h5, 8'h60, "link rx read");
        wr(3'h1, 8'h01);
        rck(3'h1, 8'h01, "irq enable");
        term.send(8'h3C);
        repeat (20) @(posedge core_clk);
        #1;
        ck("irq rx", 8'h01, {7'h00, irq});
        rck(3'h2, 8'h04, "irq source rx");
        rck(3'h0, 8'h3C, "rx byte 2");
        ck("irq clear", 8'h00, {7'h00, irq});
        wr(3'h1, 8'h00);
        @(posedge core_clk);
        cts <= 1'b1;
        repeat (8) @(posedge core_clk);
        rck(3'h6, 8'h11, "hin cts change");
        rck(3'h6, 8'h10, "hin cts now");
        wr(3'h4, 8'h03);
        @(posedge core_clk);
        #1;
        ck("modem outs", 8'h03, {4'h0, out2, out1, rts, dtr});
        // A short break; the terminal reads it as one frame of ones.
        wr(3'h3, 8'h43);
        #1;
        ck("break line", 8'h00, {7'h00, ser_out});
        wr(3'h3, 8'h03);
        wr(3'h4, 8'h13);
        wr(3'h0, 8'h96);
        hi_cnt = 8'h00;
        // The external line must stay idle while the frame loops inside.
        for (int i = 0; i < 200; i++)
        begin
            @(posedge core_clk);
            #1;
            if (ser_out === 1'b1) hi_cnt++;
        end
        ck("loop line idle", 8'hC8, hi_cnt);
        ck("loop outs", 8'h00, {4'h0, out2, out1, rts, dtr});
        rck(3'h0, 8'h96, "loop rx");
        rck(3'h6, 8'h32, "loop hin");
        // Seven bits, even parity, two stops, looped back inside.
        wr(3'h3, 8'h1E);
        wr(3'h0, 8'hD5);
        repeat (200) @(posedge core_clk);
        rck(3'h5, 8'h61, "loop parity link");
        rck(3'h0, 8'h55, "loop 7 bits");
        ck("frames seen", 8'h02, term.rx_cnt[7:0]);
        ck("stop bits", 8'h00, term.bad_stop[7:0]);
        stop_test();
    end
endmodule
